// ---- src/mmc_pkg.sv ----
package mmc_pkg;
    localparam int SC_N  = 128;
    localparam int SC_W  = 7;
    localparam int CW_W  = 24;
    localparam int CNT_W = 8;
    localparam int ADR_W = 16;
    localparam int HW    = 12;
    localparam int CH_W  = 6;
    localparam int RA_W  = 4;

    localparam logic [RA_W-1:0] REG_SEL   = 4'h0;
    localparam logic [RA_W-1:0] REG_SCCTL = 4'h1;
    localparam logic [RA_W-1:0] REG_STAT  = 4'h2;
    localparam logic [RA_W-1:0] REG_BASE  = 4'h3;
    localparam logic [RA_W-1:0] REG_CHAR  = 4'h4;

    localparam int B_START = 0;
    localparam int B_ODD   = 1;
    localparam int B_CYC   = 2;
    localparam int B_STOP  = 3;
    localparam int B_IRQC  = 4;
    localparam int B_IRQ   = 3;
    localparam int B_PERR  = 0;
    localparam int B_BUSY  = 1;
    localparam int B_LSC   = 8;
    localparam int B_DISC  = 0;
    localparam int B_TOMEM = 1;
    localparam int B_WIDE  = 2;
    localparam int B_TWO   = 3;

    localparam logic [ADR_W-1:0] BASE_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE  = 8'h01;
    localparam logic [ADR_W-1:0] ADR_ONE  = 16'h0001;
    localparam logic [HW-1:0]    HALF_ONE = 12'h001;

    typedef enum logic [1:0] {OP_DIRECT, OP_INTER, OP_INCR} mmc_op_e;
    typedef enum logic [1:0] {INC_FULL, INC_UPPER, INC_LOWER} mmc_inc_e;
    typedef enum logic [2:0] {ST_IDLE, ST_CW_RD, ST_CW_WR, ST_DATA, ST_INC_RD,
                              ST_INC_WR} mmc_st_e;

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic [ADR_W-1:0] addr;
    } mmc_cw_s;

    typedef struct packed {
        mmc_op_e         op;
        mmc_inc_e        inc;
        logic            to_mem;
        logic [ADR_W-1:0] addr;
        logic [CW_W-1:0]  data;
    } mmc_bus_s;

    typedef struct packed {
        logic            req;
        logic            we;
        logic [ADR_W-1:0] addr;
        logic [CW_W-1:0]  wdata;
        logic            wpar;
    } mmc_mem_s;
endpackage

// ---- src/mmc_char_sub.sv ----
`timescale 1ns/1ns
module mmc_char_sub (
    input  wire logic            clk_sys,
    input  wire logic            reset,
    input  wire logic            run,
    input  wire logic            to_mem,
    input  wire logic            wide,
    input  wire logic            two,
    input  wire logic            in_valid,
    output logic                 in_ready,
    input  wire logic [11:0]     in_data,
    input  wire logic [1:0]      in_par,
    output logic                 out_valid,
    input  wire logic            out_ready,
    output logic [11:0]          out_data,
    output logic [1:0]           out_par,
    input  wire logic            dev_end,
    output logic                 word_req,
    output logic [11:0]          word_out,
    input  wire logic            word_ack,
    input  wire logic [11:0]     word_in,
    output logic                 ended,
    output logic                 perr
);
    typedef struct packed {
        logic [11:0] buf_w;
        logic        half;
        logic        full;
        logic        ended;
        logic        perr;
    } mmc_cs_s;

    mmc_cs_s r_q;
    mmc_cs_s r_d;

    // In two-character mode characters sit in the upper six bits first, as they leave the device
    always_comb begin
        r_d = r_q;
        r_d.ended = run & dev_end;
        r_d.perr = 1'b0;
        if (!run) begin
            r_d.full = 1'b0;
            r_d.half = 1'b0;
        end else if (to_mem) begin
            if (in_valid && !r_q.full) begin
                if (wide) begin
                    r_d.buf_w = in_data;
                    r_d.full = 1'b1;
                    r_d.perr = ~^{in_data, in_par[0]};
                end else if (two && !r_q.half) begin
                    r_d.buf_w[11:6] = in_data[5:0];
                    r_d.half = 1'b1;
                    r_d.perr = ~^{in_data[5:0], in_par[0]};
                end else begin
                    r_d.buf_w[5:0] = in_data[5:0];
                    r_d.half = 1'b0;
                    r_d.full = 1'b1;
                    r_d.perr = ~^{in_data[5:0], in_par[0]};
                end
            end
            if (word_ack && r_q.full) begin
                r_d.full = 1'b0;
            end
        end else begin
            if (word_ack && !r_q.full) begin
                r_d.buf_w = word_in;
                r_d.full = 1'b1;
                r_d.half = 1'b0;
            end else if (out_ready && r_q.full) begin
                if (two && !wide && !r_q.half) begin
                    r_d.half = 1'b1;
                end else begin
                    r_d.full = 1'b0;
                    r_d.half = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign in_ready  = run & to_mem & ~r_q.full;
    assign word_req  = run & (to_mem ? r_q.full : ~r_q.full);
    assign word_out  = (two | wide) ? r_q.buf_w : {6'h00, r_q.buf_w[5:0]};
    assign out_valid = run & ~to_mem & r_q.full;
    assign out_data  = wide ? r_q.buf_w :
                       (two && !r_q.half) ? {6'h00, r_q.buf_w[11:6]} : {6'h00, r_q.buf_w[5:0]};
    assign out_par   = {~^out_data[11:6], ~^(wide ? out_data : {6'h00, out_data[5:0]})};
    assign ended     = r_q.ended;
    assign perr      = r_q.perr;
endmodule // mmc_char_sub

// ---- src/mmc_channel.sv ----
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ns
module mmc_channel #(
    parameter int CHAR_SC = 0
) (
    input  wire logic                             clk_sys,
    input  wire logic                             reset,
    input  wire logic [mmc_pkg::RA_W-1:0]         reg_addr,
    input  wire logic [mmc_pkg::CW_W-1:0]         reg_wdata,
    input  wire logic                             reg_wr,
    input  wire logic                             reg_rd,
    output logic [mmc_pkg::CW_W-1:0]              reg_rdata,
    input  wire logic [mmc_pkg::SC_N-1:0]         sc_req,
    input  wire mmc_pkg::mmc_bus_s                sc_bus,
    output logic                                  sc_gnt,
    output logic [mmc_pkg::SC_W-1:0]              sc_gnt_id,
    output logic                                  sc_ack,
    output logic                                  sc_zero,
    output logic [mmc_pkg::CW_W-1:0]              sc_rdata,
    output logic [mmc_pkg::SC_N-1:0]              sc_active,
    output logic [mmc_pkg::SC_N-1:0]              sc_irq,
    output mmc_pkg::mmc_mem_s                     mem_o,
    input  wire logic                             mem_gnt,
    input  wire logic [mmc_pkg::CW_W-1:0]         mem_rdata,
    input  wire logic                             mem_rpar,
    input  wire logic                             cpu_same_mem,
    output logic                                  cpu_stall,
    input  wire logic                             chr_in_valid,
    output logic                                  chr_in_ready,
    input  wire logic [11:0]                      chr_in_data,
    input  wire logic [1:0]                       chr_in_par,
    output logic                                  chr_out_valid,
    input  wire logic                             chr_out_ready,
    output logic [11:0]                           chr_out_data,
    output logic [1:0]                            chr_out_par,
    input  wire logic                             chr_end
);
    typedef struct packed {
        mmc_pkg::mmc_st_e          st;
        logic [mmc_pkg::SC_W-1:0]  sc;
        mmc_pkg::mmc_op_e          op;
        mmc_pkg::mmc_inc_e         inc;
        logic                      to_mem;
        logic [mmc_pkg::ADR_W-1:0] addr;
        logic [mmc_pkg::CW_W-1:0]  word;
        logic [mmc_pkg::CW_W-1:0]  sdata;
        logic                      zero;
        logic                      ack;
        logic                      zp;
        logic [mmc_pkg::CW_W-1:0]  rdata;
        logic [mmc_pkg::CW_W-1:0]  reg_rd;
        logic [mmc_pkg::SC_W-1:0]  sel;
        logic [mmc_pkg::ADR_W-1:0] base;
        logic                      perr;
        logic [3:0]                chr_cfg;
        logic [mmc_pkg::SC_N-1:0]  act;
        logic [mmc_pkg::SC_N-1:0]  odd;
        logic [mmc_pkg::SC_N-1:0]  cyc;
        logic [mmc_pkg::SC_N-1:0]  irq;
    } mmc_state_s;

    mmc_state_s               r_q;
    mmc_state_s               r_d;
    logic                     any_req;
    logic [mmc_pkg::SC_W-1:0] win;
    logic [mmc_pkg::SC_N-1:0] req_all;
    mmc_pkg::mmc_bus_s        bus;
    logic                     chr_req;
    logic [11:0]              chr_word;
    logic                     chr_ack;
    logic                     chr_ended;
    logic                     chr_perr;
    logic                     chr_run;
    logic                     mem_done;
    logic                     rd_bad;

    assign chr_run = r_q.act[CHAR_SC];

    mmc_char_sub u_char (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .run       (chr_run),
        .to_mem    (r_q.chr_cfg[mmc_pkg::B_TOMEM]),
        .wide      (r_q.chr_cfg[mmc_pkg::B_WIDE]),
        .two       (r_q.chr_cfg[mmc_pkg::B_TWO]),
        .in_valid  (chr_in_valid),
        .in_ready  (chr_in_ready),
        .in_data   (chr_in_data),
        .in_par    (chr_in_par),
        .out_valid (chr_out_valid),
        .out_ready (chr_out_ready),
        .out_data  (chr_out_data),
        .out_par   (chr_out_par),
        .dev_end   (chr_end),
        .word_req  (chr_req),
        .word_out  (chr_word),
        .word_ack  (chr_ack),
        .word_in   (r_q.rdata[11:0]),
        .ended     (chr_ended),
        .perr      (chr_perr)
    );

    // Lowest number wins; a fixed order keeps the decision one cycle deep
    always_comb begin
        req_all = sc_req;
        req_all[CHAR_SC] = chr_req;
        any_req = 1'b0;
        win = '0;
        for (int i = mmc_pkg::SC_N - 1; i >= 0; i--) begin
            if (req_all[i]) begin
                any_req = 1'b1;
                win = mmc_pkg::SC_W'(i);
            end
        end
        bus = sc_bus;
        if (win == mmc_pkg::SC_W'(CHAR_SC)) begin
            bus.op = mmc_pkg::OP_INTER;
            bus.inc = mmc_pkg::INC_FULL;
            bus.to_mem = r_q.chr_cfg[mmc_pkg::B_TOMEM];
            bus.addr = '0;
            bus.data = {12'h000, chr_word};
        end
    end

    assign mem_done = r_q.st != mmc_pkg::ST_IDLE && mem_gnt;
    assign rd_bad   = mem_done && !mem_o.we && !(^{mem_rdata, mem_rpar});

    always_comb begin
        mmc_pkg::mmc_cw_s cw;
        logic [mmc_pkg::CW_W-1:0] v;
        cw = mmc_pkg::mmc_cw_s'(mem_rdata);
        v = mem_rdata;
        r_d = r_q;
        r_d.ack = 1'b0;
        r_d.zp = 1'b0;
        r_d.reg_rd = '0;
        // Software writes first so hardware events below override a clear
        if (reg_wr) begin
            case (reg_addr)
                mmc_pkg::REG_SEL: r_d.sel = reg_wdata[mmc_pkg::SC_W-1:0];
                mmc_pkg::REG_SCCTL: begin
                    if (reg_wdata[mmc_pkg::B_START]) begin
                        r_d.act[r_q.sel] = 1'b1;
                        r_d.odd[r_q.sel] = reg_wdata[mmc_pkg::B_ODD];
                        r_d.cyc[r_q.sel] = reg_wdata[mmc_pkg::B_CYC];
                    end
                    if (reg_wdata[mmc_pkg::B_STOP]) begin
                        r_d.act[r_q.sel] = 1'b0;
                    end
                    if (reg_wdata[mmc_pkg::B_IRQC]) begin
                        r_d.irq[r_q.sel] = 1'b0;
                    end
                end
                mmc_pkg::REG_STAT: begin
                    if (reg_wdata[mmc_pkg::B_PERR]) begin
                        r_d.perr = 1'b0;
                    end
                end
                mmc_pkg::REG_BASE: r_d.base = reg_wdata[mmc_pkg::ADR_W-1:0];
                mmc_pkg::REG_CHAR: r_d.chr_cfg = reg_wdata[3:0];
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                mmc_pkg::REG_SEL: r_d.reg_rd = mmc_pkg::CW_W'(r_q.sel);
                mmc_pkg::REG_SCCTL: begin
                    r_d.reg_rd[mmc_pkg::B_START] = r_q.act[r_q.sel];
                    r_d.reg_rd[mmc_pkg::B_ODD] = r_q.odd[r_q.sel];
                    r_d.reg_rd[mmc_pkg::B_CYC] = r_q.cyc[r_q.sel];
                    r_d.reg_rd[mmc_pkg::B_IRQ] = r_q.irq[r_q.sel];
                end
                mmc_pkg::REG_STAT: begin
                    r_d.reg_rd[mmc_pkg::B_PERR] = r_q.perr;
                    r_d.reg_rd[mmc_pkg::B_BUSY] = r_q.st != mmc_pkg::ST_IDLE;
                    r_d.reg_rd[mmc_pkg::B_LSC +: mmc_pkg::SC_W] = r_q.sc;
                end
                mmc_pkg::REG_BASE: r_d.reg_rd = mmc_pkg::CW_W'(r_q.base);
                mmc_pkg::REG_CHAR: r_d.reg_rd = mmc_pkg::CW_W'(r_q.chr_cfg);
                default: r_d.reg_rd = '0;
            endcase
        end
        if (rd_bad || chr_perr) begin
            r_d.perr = 1'b1;
        end
        if (chr_ended) begin
            r_d.act[CHAR_SC] = 1'b0;
            r_d.irq[CHAR_SC] = 1'b1;
        end
        case (r_q.st)
            mmc_pkg::ST_IDLE: begin
                // Skip the ack cycle: the finished requester still holds its line there
                if (any_req && !r_q.ack) begin
                    r_d.sc = win;
                    r_d.op = bus.op;
                    r_d.inc = bus.inc;
                    r_d.to_mem = bus.to_mem;
                    r_d.sdata = bus.data;
                    r_d.word = bus.data;
                    r_d.addr = bus.addr;
                    case (bus.op)
                        mmc_pkg::OP_INCR: r_d.st = mmc_pkg::ST_INC_RD;
                        mmc_pkg::OP_INTER: begin
                            if (r_q.act[win]) begin
                                r_d.addr = r_q.base +
                                    mmc_pkg::ADR_W'({win, r_q.odd[win]});
                                r_d.st = mmc_pkg::ST_CW_RD;
                            end else begin
                                r_d.ack = 1'b1;
                            end
                        end
                        default: r_d.st = mmc_pkg::ST_DATA;
                    endcase
                end
            end
            mmc_pkg::ST_CW_RD: begin
                if (mem_gnt) begin
                    // A count of zero wraps to 255 here, giving a 256-word block
                    r_d.word = {cw.count - mmc_pkg::CNT_ONE,
                                cw.addr + mmc_pkg::ADR_ONE};
                    r_d.zero = (cw.count - mmc_pkg::CNT_ONE) == '0;
                    r_d.st = mmc_pkg::ST_CW_WR;
                end
            end
            mmc_pkg::ST_CW_WR: begin
                if (mem_gnt) begin
                    r_d.addr = r_q.word[mmc_pkg::ADR_W-1:0];
                    r_d.word = r_q.sdata;
                    r_d.st = mmc_pkg::ST_DATA;
                end
            end
            mmc_pkg::ST_DATA: begin
                if (mem_gnt) begin
                    if (!r_q.to_mem) begin
                        r_d.rdata = mem_rdata;
                    end
                    r_d.ack = 1'b1;
                    r_d.st = mmc_pkg::ST_IDLE;
                    if (r_q.op == mmc_pkg::OP_INTER && r_q.zero) begin
                        r_d.zp = 1'b1;
                        r_d.irq[r_q.sc] = 1'b1;
                        if (!r_q.odd[r_q.sc]) begin
                            r_d.odd[r_q.sc] = 1'b1;
                        end else if (r_q.cyc[r_q.sc]) begin
                            r_d.odd[r_q.sc] = 1'b0;
                        end else begin
                            r_d.act[r_q.sc] = 1'b0;
                        end
                        if (r_q.sc == mmc_pkg::SC_W'(CHAR_SC) &&
                            r_q.chr_cfg[mmc_pkg::B_DISC] && r_q.chr_cfg[mmc_pkg::B_TOMEM]) begin
                            r_d.act[r_q.sc] = 1'b0;
                        end
                    end
                end
            end
            mmc_pkg::ST_INC_RD: begin
                if (mem_gnt) begin
                    case (r_q.inc)
                        mmc_pkg::INC_UPPER: begin
                            v[23:12] = mem_rdata[23:12] + mmc_pkg::HALF_ONE;
                            r_d.zero = v[23:12] == '0;
                        end
                        mmc_pkg::INC_LOWER: begin
                            v[11:0] = mem_rdata[11:0] + mmc_pkg::HALF_ONE;
                            r_d.zero = v[11:0] == '0;
                        end
                        default: begin
                            v = mem_rdata + mmc_pkg::CW_W'(1);
                            r_d.zero = v == '0;
                        end
                    endcase
                    r_d.word = v;
                    r_d.st = mmc_pkg::ST_INC_WR;
                end
            end
            mmc_pkg::ST_INC_WR: begin
                if (mem_gnt) begin
                    // Read and restore are two cycles, so increments cannot run faster
                    r_d.ack = 1'b1;
                    r_d.zp = r_q.zero;
                    if (r_q.zero) begin
                        r_d.irq[r_q.sc] = 1'b1;
                    end
                    r_d.st = mmc_pkg::ST_IDLE;
                end
            end
            default: r_d.st = mmc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            r_q <= '0;
            r_q.st <= mmc_pkg::ST_IDLE;
            r_q.base <= mmc_pkg::BASE_RST;
        end else begin
            r_q <= r_d;
        end
    end

    always_comb begin
        mem_o = '0;
        if (r_q.st != mmc_pkg::ST_IDLE) begin
            mem_o.req = 1'b1;
            mem_o.addr = r_q.addr;
            mem_o.we = r_q.st == mmc_pkg::ST_CW_WR || r_q.st == mmc_pkg::ST_INC_WR ||
                       (r_q.st == mmc_pkg::ST_DATA && r_q.to_mem);
            if (mem_o.we) begin
                mem_o.wdata = r_q.word;
                mem_o.wpar = ~^r_q.word;
            end
        end
    end

    // The processor only loses the cycle when both want the same memory
    assign cpu_stall = mem_done & cpu_same_mem;
    assign sc_gnt    = r_q.st == mmc_pkg::ST_IDLE && any_req && !r_q.ack;
    assign sc_gnt_id = win;
    assign chr_ack   = r_q.ack && r_q.sc == mmc_pkg::SC_W'(CHAR_SC);
    assign sc_ack    = r_q.ack;
    assign sc_zero   = r_q.zp;
    assign sc_rdata  = r_q.rdata;
    assign sc_active = r_q.act;
    assign sc_irq    = r_q.irq;
    assign reg_rdata = r_q.reg_rd;
endmodule // mmc_channel

// ---- sim/mmc_channel_chk.sv ----
`timescale 1ns/1ns
module mmc_chk (
    input wire logic              clk_sys,
    input wire logic              reset,
    input wire logic [127:0]      sc_req,
    input wire logic              sc_gnt,
    input wire logic [6:0]        sc_gnt_id,
    input wire logic              sc_ack,
    input wire logic              sc_zero,
    input wire mmc_pkg::mmc_mem_s mem_o,
    input wire logic              mem_gnt,
    input wire logic              cpu_same_mem,
    input wire logic              cpu_stall
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    stall_once_a: assert property (cpu_stall == (mem_o.req && mem_gnt && cpu_same_mem))
        else $error("stall wrong");
    bus_quiet_a: assert property (!mem_o.req |-> mem_o == '0)
        else $error("bus driven while idle");
    par_odd_a: assert property (mem_o.we |-> ^{mem_o.wdata, mem_o.wpar})
        else $error("bad write parity");
    req_hold_a: assert property (mem_o.req && !mem_gnt |=> $stable(mem_o))
        else $error("request moved before grant");
    zero_ack_a: assert property (sc_zero |-> sc_ack)
        else $error("zero without ack");
    gnt_prio_a:
        // Bit 0 belongs to the character unit, whose request is internal
        assert property (sc_gnt |-> (sc_gnt_id == 7'h00 || sc_req[sc_gnt_id]) &&
            (sc_req & ((128'h1 << sc_gnt_id) - 128'h1) & ~128'h1) == 128'h0)
        else $error("grant not lowest requester");
    gnt_once_a: assert property (sc_gnt |=> !sc_gnt)
        else $error("grant repeated");
    ack_gap_a: assert property (sc_ack |=> !sc_ack)
        else $error("ack repeated");
endmodule // mmc_chk
bind mmc_channel mmc_chk u_chk (.clk_sys, .reset, .sc_req, .sc_gnt, .sc_gnt_id, .sc_ack,
    .sc_zero, .mem_o, .mem_gnt, .cpu_same_mem, .cpu_stall);

// ---- sim/mmc_mem_model.sv ----
`timescale 1ns/1ns
module mmc_mem_model (
    input  wire logic              clk_sys,
    input  wire mmc_pkg::mmc_mem_s mem_o,
    input  wire logic              slow,
    input  wire logic              bad_par,
    output logic                   mem_gnt,
    output logic [23:0]            mem_rdata,
    output logic                   mem_rpar
);
    logic [23:0] m [65536];
    logic        coin = 1'b1;
    always @(posedge clk_sys) begin
        coin <= !slow || 1'($urandom_range(1));
        if (mem_gnt && mem_o.we) m[mem_o.addr] <= mem_o.wdata;
    end
    // Ungranted cycles show the inverse, so stale data never looks valid
    always_comb begin
        mem_gnt = mem_o.req && coin;
        mem_rdata = mem_gnt ? m[mem_o.addr] : ~m[mem_o.addr];
        mem_rpar = ~^mem_rdata ^ bad_par;
    end
endmodule // mmc_mem_model

// ---- sim/mmc_tb.sv ----
`timescale 1ns/1ns
module multiplexed_memory_channel_tb_top;
    logic              clk_sys = 1'b0, reset = 1'b1, reg_wr, reg_rd, sc_ack, sc_zero, mem_gnt;
    logic              mem_rpar, cpu_same_mem, slow, bad_par, zf, fr, chr_in_valid, chr_end;
    logic [11:0]       chr_in_data;
    logic [1:0]        chr_in_par;
    logic [3:0]        reg_addr;
    logic [23:0]       reg_wdata, reg_rdata, mem_rdata, rv, d, ev, sc_rdata, cwm [2];
    logic [127:0]      sc_req, sc_irq, sc_active;
    logic [15:0]       a, cb;
    logic [23:0]       wv [4] = '{24'hffffff, 24'hfff123, 24'h456fff, 24'h00000f};
    logic [23:0]       xv [4] = '{24'h000000, 24'h000123, 24'h456000, 24'h000010};
    mmc_pkg::mmc_bus_s sc_bus;
    mmc_pkg::mmc_mem_s mem_o;
    int                failures = 0, n_checks = 0, g, s, k;
    mmc_channel DUT (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .sc_req, .sc_bus, .sc_gnt(), .sc_gnt_id(), .sc_ack, .sc_zero, .sc_rdata, .sc_active,
        .sc_irq, .mem_o, .mem_gnt, .mem_rdata, .mem_rpar, .cpu_same_mem, .cpu_stall(),
        .chr_in_valid, .chr_in_ready(), .chr_in_data, .chr_in_par,
        .chr_out_valid(), .chr_out_ready(1'b0), .chr_out_data(), .chr_out_par(), .chr_end);
    mmc_mem_model u_mem (.clk_sys, .mem_o, .slow, .bad_par, .mem_gnt, .mem_rdata, .mem_rpar);
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cpu_same_mem <= 1'($urandom_range(1));
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [3:0] ad, input logic [23:0] v);
        @(posedge clk_sys);
        {reg_addr, reg_wdata, reg_wr} <= {ad, v, 1'b1};
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] ad);
        @(posedge clk_sys);
        {reg_addr, reg_rd} <= {ad, 1'b1};
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        rv = reg_rdata;
    endtask
    // Request held until ack; granted memory cycles are counted meanwhile
    task automatic op(input mmc_pkg::mmc_op_e o, input mmc_pkg::mmc_inc_e i, input logic [15:0] ad);
        g = 0;
        @(posedge clk_sys);
        sc_bus <= '{o, i, !fr, ad, d};
        sc_req[s] <= 1'b1;
        for (k = 0; k < 80 && sc_ack !== 1'b1; k++) begin
            @(negedge clk_sys);
            g += int'(mem_o.req && mem_gnt);
        end
        zf = sc_zero;
        failures += int'(k == 80);
        if (k == 80) complete_run();
        @(posedge clk_sys);
        sc_req[s] <= 1'b0;
    endtask
    initial begin
        {reg_wr, reg_rd, slow, bad_par, fr, chr_in_valid, chr_end, chr_in_data, chr_in_par,
            reg_addr, reg_wdata, sc_req, sc_bus} = '0;
        s = $urandom(32'hb01e);
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        s = $urandom_range(127, 2);
        a = 16'($urandom_range(16'h7000, 16'h4000));
        cwm = '{{8'h01, a}, {8'h01, a + 16'h0800}};
        cb = 16'h1000;
        wr(mmc_pkg::REG_BASE, {8'h00, cb});
        wr(mmc_pkg::REG_SEL, 24'(s));
        wr(mmc_pkg::REG_SCCTL, 24'h000005);
        for (int j = 0; j < 2; j++) u_mem.m[cb + 16'(2 * s + j)] = cwm[j];
        for (int j = 0; j < 3; j++) begin
            slow <= j[0];
            d = $urandom();
            ev = {cwm[j % 2][23:16] - 8'h01, cwm[j % 2][15:0] + 16'h0001};
            cwm[j % 2] = ev;
            op(mmc_pkg::OP_INTER, mmc_pkg::INC_FULL, cb + 16'(2 * s + j % 2));
            chk(u_mem.m[cb + 16'(2 * s + j % 2)], ev);
            chk(u_mem.m[ev[15:0]], d);
            chk(24'(g), 24'h000003);
            chk({23'h0, zf}, {23'h0, ev[23:16] == 8'h00});
        end
        rd(mmc_pkg::REG_SCCTL);
        chk(rv, 24'h00000d);
        chk({23'h0, sc_irq[s]}, 24'h000001);
        for (int j = 0; j < 4; j++) begin
            u_mem.m[a] = wv[j];
            op(mmc_pkg::OP_INCR, mmc_pkg::mmc_inc_e'(2'(j % 3)), a);
            chk(u_mem.m[a], xv[j]);
            chk({23'h0, zf}, {23'h0, j < 3});
            chk(24'(g), 24'h000002);
        end
        bad_par <= 1'b1;
        op(mmc_pkg::OP_INCR, mmc_pkg::INC_FULL, a);
        bad_par <= 1'b0;
        rd(mmc_pkg::REG_STAT);
        chk(rv & 24'h1, 24'h000001);
        wr(mmc_pkg::REG_STAT, 24'h000001);
        rd(mmc_pkg::REG_STAT);
        chk(rv & 24'h1, 24'h000000);
        s = s ^ 1;
        op(mmc_pkg::OP_INTER, mmc_pkg::INC_FULL, cb);
        chk(24'(g), 24'h000000);
        op(mmc_pkg::OP_DIRECT, mmc_pkg::INC_FULL, a);
        chk(u_mem.m[a], d);
        chk(24'(g), 24'h000001);
        // Character unit owns subchannel 0: one 12-bit character into memory
        u_mem.m[cb] = {8'h05, a};
        wr(mmc_pkg::REG_CHAR, 24'h000006);
        wr(mmc_pkg::REG_SEL, 24'h000000);
        wr(mmc_pkg::REG_SCCTL, 24'h000001);
        {chr_in_valid, chr_in_data, chr_in_par} <= {1'b1, d[11:0], 1'b0, ~^d[11:0]};
        @(posedge clk_sys);
        chr_in_valid <= 1'b0;
        repeat (8) @(negedge clk_sys);
        chk(u_mem.m[a + 16'h0001], {12'h000, d[11:0]});
        chk(u_mem.m[cb], {8'h04, a + 16'h0001});
        @(posedge clk_sys);
        chr_end <= 1'b1;
        @(posedge clk_sys);
        chr_end <= 1'b0;
        repeat (2) @(negedge clk_sys);
        chk({22'h0, sc_active[0], sc_irq[0]}, 24'h000001);
        fr = 1'b1;
        op(mmc_pkg::OP_DIRECT, mmc_pkg::INC_FULL, a + 16'h0001);
        chk(sc_rdata, u_mem.m[a + 16'h0001]);
        rd(4'hf);
        chk(rv, 24'h000000);
        complete_run();
    end
endmodule // multiplexed_memory_channel_tb_top
